// ---- rtl/ppei_port_unit.sv ----
/*
  Port interrupt unit for one eight-pin port: reset release, per-pin edge
  detection, sticky pin status, one interrupt request and a wake request.
  Assumes the interrupt controller owns this port's vector, that the CPU
  pulses status_read_in for one cycle when it reads status_out, and that
  clk_in keeps running in sleep, since this unit gates nothing itself.
  A pin change reaches status_out four clocks after the first synchroniser
  stage samples it; pulses shorter than two clocks may be missed.
*/
// Functional notes
// - Every pin of the port can produce an interrupt event.
// - Eight pins of a port share one unit with its own request line.
// - Each pin is set on its own to rising, falling, both or no edge.
// - A matching edge sets the pin's status bit and raises the request.
// - The unit has its own request and pin status so the source is plain.
// - Detection and request keep working in every sleep mode.
// - Only edges are detected; there is no level-sensitive mode.
// - Each pin's input buffer can be disabled regardless of drive mode.
`timescale 1ns/100ps
module ppei_port_unit #(
  parameter int NUM_PINS = ppei_pkg::PORT_PINS
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Port pins
  input wire logic [NUM_PINS-1:0] pins_in,
  // Per-pin configuration
  input wire logic [NUM_PINS*ppei_pkg::MODE_W-1:0] pin_mode_in,
  input wire logic [NUM_PINS-1:0] buf_dis_in,
  // CPU status access
  input wire logic status_read_in,
  output logic [NUM_PINS-1:0] status_out,
  // Interrupt controller and power manager
  output logic irq_out,
  output logic wake_out
);
  import ppei_pkg::*;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic [NUM_PINS-1:0] pin_event;
  logic [NUM_PINS-1:0] status_reg;
  logic [NUM_PINS-1:0] status_next;
  logic irq_reg;
  logic wake_reg;

  // Reset release passes two flops; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      ppei_pin_edge u_edge (
        .clk_in(clk_in),
        .rst_n_in(rst_sync_reg),
        .pin_in(pins_in[i]),
        .buf_dis_in(buf_dis_in[i]),
        .mode_in(pin_mode_in[i*MODE_W +: MODE_W]),
        .event_out(pin_event[i])
      );
    end
  endgenerate

  // New edges win over a read in the same cycle, so no event is lost
  always_comb begin
    status_next = status_reg;
    if (status_read_in) begin
      status_next = {NUM_PINS{STATUS_RST}};
    end
    status_next = status_next | pin_event;
  end

  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      status_reg <= {NUM_PINS{STATUS_RST}};
    end else begin
      status_reg <= status_next;
    end
  end

  // Request and wake follow the status directly. No clock gating lives
  // here: in sleep the clock to this unit must keep running for wake-up.
  always_ff @(posedge clk_in or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= |status_next;
      wake_reg <= |status_next;
    end
  end

  assign status_out = status_reg;
  assign irq_out = irq_reg;
  assign wake_out = wake_reg;

  a_status_sets: assert property (@(posedge clk_in)
    disable iff (!rst_sync_reg)
    (|pin_event) |=> ((status_out & $past(pin_event)) == $past(pin_event)))
    else $error("edge did not set status bit");
  a_irq_tracks: assert property (@(posedge clk_in)
    disable iff (!rst_sync_reg) irq_out == (|status_out))
    else $error("request does not match status");
  a_read_clears: assert property (@(posedge clk_in)
    disable iff (!rst_sync_reg)
    (status_read_in && !(|pin_event)) |=> (status_out == '0) && !irq_out)
    else $error("read did not clear status");
  a_read_keeps_new: assert property (@(posedge clk_in)
    disable iff (!rst_sync_reg)
    (status_read_in && (|pin_event)) |=> irq_out && wake_out)
    else $error("edge lost under read");
  a_wake_follows: assert property (@(posedge clk_in)
    disable iff (!rst_sync_reg) (|pin_event) |=> wake_out ##0 irq_out)
    else $error("no wake request on edge");
  a_status_holds: assert property (@(posedge clk_in)
    disable iff (!rst_sync_reg)
    (!status_read_in && (|status_out)) |=> (|status_out))
    else $error("status dropped without a read");
  a_wake_irq_same: assert property (@(posedge clk_in)
    disable iff (!rst_sync_reg) wake_out == irq_out)
    else $error("wake request differs from interrupt request");
  a_reset_clear: assert property (@(posedge clk_in)
    !rst_sync_reg |-> (status_out == '0) && !irq_out && !wake_out)
    else $error("outputs not clear during reset");
  a_sync_two_flops: assert property (@(posedge clk_in)
    rst_sync_reg |-> $past(rst_meta_reg))
    else $error("reset released without the first flop");

  // Per-pin view of the sticky status, so that a busy pin cannot hide a
  // lost or spurious bit on its neighbour behind the port-wide OR
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin_chk
      a_pin_sets: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        pin_event[i] |=> status_reg[i])
        else $error("pin event did not set its bit");
      a_pin_holds: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        (status_reg[i] && !status_read_in) |=> status_reg[i])
        else $error("pin bit dropped without a read");
      a_pin_no_spur: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        (!status_reg[i] && !pin_event[i]) |=> !status_reg[i])
        else $error("pin bit set without an event");
      a_pin_read_clear: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        (status_read_in && !pin_event[i]) |=> !status_reg[i])
        else $error("pin bit survived a read");
      a_pin_read_keep: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        (status_read_in && pin_event[i]) |=> status_reg[i])
        else $error("pin event lost under a read");
      a_pin_none_quiet: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        (pin_mode_in[i*MODE_W +: MODE_W] == MODE_NONE) |=> !pin_event[i])
        else $error("pin event with mode none");
      a_pin_buf_quiet: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        buf_dis_in[i] |=> !pin_event[i])
        else $error("pin event from a disabled buffer");
      a_pin_event_gap: assert property (@(posedge clk_in)
        disable iff (!rst_sync_reg)
        pin_event[i] |=> !pin_event[i])
        else $error("pin event repeated without a new edge");
    end
  endgenerate

  c_read_clear: cover property (@(posedge clk_in)
    disable iff (!rst_sync_reg) irq_out ##1 status_read_in ##1 !irq_out);
  c_read_collide: cover property (@(posedge clk_in)
    disable iff (!rst_sync_reg) status_read_in && (|pin_event));
endmodule : ppei_port_unit

// ---- rtl/ppei_pkg.sv ----
/*
  Shared constants for the port pin edge interrupt unit: edge mode codes,
  port width and reset values.
  Assumes nothing beyond a SystemVerilog compiler that sees this file first.
*/
package ppei_pkg;
  // Pins grouped on one port interrupt unit
  localparam int PORT_PINS = 8;
  // Per-pin edge mode field
  localparam int MODE_W = 2;
  localparam logic [MODE_W-1:0] MODE_NONE = 2'h0;
  localparam logic [MODE_W-1:0] MODE_RISE = 2'h1;
  localparam logic [MODE_W-1:0] MODE_FALL = 2'h2;
  localparam logic [MODE_W-1:0] MODE_BOTH = 2'h3;
  // Reset values
  localparam logic STATUS_RST = 1'h0;
  localparam logic LEVEL_RST = 1'h0;
endpackage : ppei_pkg

// ---- rtl/ppei_pin_edge.sv ----
/*
  One pin of the port interrupt unit: three-stage pin synchroniser, stable
  level tracking and edge qualification against the pin's mode.
  Assumes an active-low reset already synchronised to clk_in.
*/
`timescale 1ns/100ps
module ppei_pin_edge (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Pin and configuration
  input wire logic pin_in,
  input wire logic buf_dis_in,
  input wire logic [ppei_pkg::MODE_W-1:0] mode_in,
  // Event
  output logic event_out
);
  import ppei_pkg::*;

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic fill1_reg;
  logic fill2_reg;
  logic fill3_reg;
  logic level_reg;
  logic primed_reg;
  logic event_reg;
  logic stable;
  logic rise;
  logic fall;
  logic event_next;

  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg <= LEVEL_RST;
      s2_reg <= LEVEL_RST;
      s3_reg <= LEVEL_RST;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Marks the cycles from which stage three holds a real pin sample
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fill1_reg <= 1'b0;
      fill2_reg <= 1'b0;
      fill3_reg <= 1'b0;
    end else begin
      fill1_reg <= 1'b1;
      fill2_reg <= fill1_reg;
      fill3_reg <= fill2_reg;
    end
  end

  // A change counts only once stages two and three agree
  assign stable = (s2_reg == s3_reg);
  assign rise = stable && s3_reg && !level_reg;
  assign fall = stable && !s3_reg && level_reg;

  always_comb begin
    event_next = 1'b0;
    if (primed_reg && !buf_dis_in) begin
      case (mode_in)
        MODE_RISE: event_next = rise;
        MODE_FALL: event_next = fall;
        MODE_BOTH: event_next = rise || fall;
        MODE_NONE: event_next = 1'b0;
        default: event_next = 1'b0;
      endcase
    end
  end

  // The stages' reset value is no pin sample: only an agreed sample taken
  // once the chain has filled arms the detector, so a pin that idles high
  // gives no false rising edge after reset. A disabled buffer freezes it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_reg <= LEVEL_RST;
      primed_reg <= 1'b0;
    end else if (stable && !buf_dis_in) begin
      level_reg <= s3_reg;
      primed_reg <= fill3_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      event_reg <= 1'b0;
    end else begin
      event_reg <= event_next;
    end
  end

  assign event_out = event_reg;

  a_mode_none_quiet: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) (mode_in == MODE_NONE) |=> !event_reg)
    else $error("event raised with mode none");
  a_rise_level_high: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (event_reg && $past(mode_in) == MODE_RISE) |-> level_reg)
    else $error("rising event without high level");
  a_fall_level_low: assert property (@(posedge clk_in)
    disable iff (!rst_n_in)
    (event_reg && $past(mode_in) == MODE_FALL) |-> !level_reg)
    else $error("falling event without low level");
  a_buf_dis_quiet: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) buf_dis_in |=> !event_reg)
    else $error("event from disabled input buffer");
  a_edge_only_event: assert property (@(posedge clk_in)
    disable iff (!rst_n_in) event_reg |-> $changed(level_reg))
    else $error("event without a level change");
  c_rise_event: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    event_reg && $past(mode_in) == MODE_RISE);
  c_both_event: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    event_reg && $past(mode_in) == MODE_BOTH);
endmodule : ppei_pin_edge

// ---- dv/ppei_cpu_model.sv ----
/*
  Behavioural CPU and interrupt controller for one port unit.
  Assumes the bench drives enable and delay; it reads at a negedge.
*/
`timescale 1ns/100ps
module ppei_cpu_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Service control
  input wire logic enable_in,
  input wire logic [3:0] delay_in,
  // Port unit side
  input wire logic irq_in,
  input wire logic [7:0] status_in,
  output logic read_out,
  output logic [7:0] seen_out
);
  logic [3:0] cnt_reg;
  // Read strobe spans exactly one rising edge
  always @(negedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_out <= 1'b0;
      cnt_reg <= 4'h0;
      seen_out <= 8'h00;
    end else if (read_out) begin
      read_out <= 1'b0;
    end else if (enable_in && irq_in) begin
      if (cnt_reg == delay_in) begin
        read_out <= 1'b1;
        seen_out <= status_in;
        cnt_reg <= 4'h0;
      end else begin
        cnt_reg <= cnt_reg + 4'h1;
      end
    end
  end
endmodule : ppei_cpu_model

// ---- dv/tb_port_pin_edge_interrupt_unit.sv ----
/*
  Self-checking bench for the port unit with a CPU model on its far side.
  Assumes inputs change on the falling clock edge only.
*/
`timescale 1ns/100ps
module tb_port_pin_edge_interrupt_unit;
  import ppei_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pins = 8'h00;
  logic [15:0] mode = 16'h0000;
  logic [7:0] buf_dis = 8'h00;
  logic tb_rd = 1'b0;
  logic cpu_en = 1'b0;
  logic [3:0] cpu_dly = 4'h0;
  logic cpu_rd;
  logic irq;
  logic wake;
  logic [7:0] status;
  logic [7:0] seen;
  int errors = 0;
  int comparisons = 0;
  always #12.5 clk = ~clk;
  ppei_port_unit #(.NUM_PINS(8)) u_ppei_port_unit (.clk_in(clk),
    .rst_n_in(rst_n), .pins_in(pins), .pin_mode_in(mode),
    .buf_dis_in(buf_dis), .status_read_in(tb_rd | cpu_rd),
    .status_out(status), .irq_out(irq), .wake_out(wake));
  ppei_cpu_model u_ppei_cpu_model (.clk_in(clk), .rst_n_in(rst_n),
    .enable_in(cpu_en), .delay_in(cpu_dly), .irq_in(irq),
    .status_in(status), .read_out(cpu_rd), .seen_out(seen));
  task automatic close_out;
    if (errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic check(input logic [9:0] got, input logic [9:0] want);
    comparisons++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic wait_irq(input logic [7:0] want);
    int n;
    for (n = 0; n < 10 && irq !== 1'b1; n++) @(negedge clk);
    if (irq !== 1'b1) begin
      errors++;
      close_out();
    end
    check({irq, wake, status}, {2'b11, want});
  endtask : wait_irq
  task automatic read_clear;
    @(negedge clk) tb_rd = 1'b1;
    @(negedge clk) tb_rd = 1'b0;
    check({irq, wake, status}, 10'h000);
  endtask : read_clear
  // Pin i gets mode i mod 4, so every mode is exercised on both edges
  task automatic modes_scan;
    mode = {2{MODE_BOTH, MODE_FALL, MODE_RISE, MODE_NONE}};
    @(negedge clk) pins = 8'hff;
    wait_irq(8'haa);
    read_clear();
    @(negedge clk) pins = 8'h00;
    wait_irq(8'hcc);
    read_clear();
  endtask : modes_scan
  // Disabled buffers stay silent; a held level never re-triggers
  task automatic edge_only;
    mode = {8{MODE_BOTH}};
    buf_dis = 8'h0f;
    @(negedge clk) pins = 8'hff;
    wait_irq(8'hf0);
    read_clear();
    repeat (10) @(negedge clk);
    check({irq, wake, status}, 10'h000);
  endtask : edge_only
  // A read in the cycle a new edge lands clears old bits, keeps the new one
  task automatic read_collide;
    @(negedge clk) pins[5] = ~pins[5];
    wait_irq(8'h20);
    @(negedge clk) pins[6] = ~pins[6];
    repeat (4) @(negedge clk);
    tb_rd = 1'b1;
    @(negedge clk) tb_rd = 1'b0;
    check({irq, wake, status}, {2'b11, 8'h40});
    read_clear();
  endtask : read_collide
  // A mid-run reset with pins held high must raise no false edge
  task automatic reset_quiet;
    cpu_en = 1'b0;
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    check({irq, wake, status}, 10'h000);
    @(negedge clk) pins[7] = ~pins[7];
    wait_irq(8'h80);
  endtask : reset_quiet
  // CPU model services pin 4 promptly and then slowly
  task automatic cpu_service;
    int n;
    cpu_en = 1'b1;
    for (int d = 0; d < 2; d++) begin
      cpu_dly = d ? 4'h9 : 4'h0;
      @(negedge clk) pins[4] = ~pins[4];
      for (n = 0; n < 30 && cpu_rd !== 1'b1; n++) @(posedge clk);
      if (cpu_rd !== 1'b1) begin
        errors++;
        close_out();
      end
      @(negedge clk);
      check({2'b00, seen}, 10'h010);
      check({irq, wake, status}, 10'h000);
    end
  endtask : cpu_service
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check({irq, wake, status}, 10'h000);
    modes_scan();
    edge_only();
    read_collide();
    cpu_service();
    reset_quiet();
    close_out();
  end
endmodule : tb_port_pin_edge_interrupt_unit
